// *** bench/asp_remote_end.sv ***
/* Remote serial transceiver on the far side of the pads.
   Assumes the bench sets bit_clks to the bit time in system clocks. */
`timescale 1ns/1ps
// ============================================================
// Remote transceiver
module asp_remote_end (
    input  wire clk_i,
    input  wire tx_line_i,
    output reg  rx_line_o
);
    int bit_clks = 64;
    // Idle line sits high, as a pulled-up pad would
    initial rx_line_o = 1'b1;
    // One frame: low start, n bits LSB first, one high stop
    task automatic send(input logic [8:0] bits, input int n);
        int i;
        @(posedge clk_i);
        rx_line_o <= 1'b0;
        repeat (bit_clks) @(posedge clk_i);
        for (i = 0; i < n; i++) begin
            rx_line_o <= bits[i];
            repeat (bit_clks) @(posedge clk_i);
        end
        rx_line_o <= 1'b1;
        repeat (bit_clks) @(posedge clk_i);
    endtask
    // Mid-bit sampling tolerates a few clocks of rate rounding
    task automatic catch(input int n, output logic [8:0] bits, output logic ok);
        int i;
        bits = 9'h000;
        ok = 1'b0;
        for (i = 0; i < 4000 && tx_line_i !== 1'b0; i++) @(posedge clk_i);
        if (tx_line_i === 1'b0) begin
            repeat (bit_clks / 2) @(posedge clk_i);
            for (i = 0; i < n; i++) begin
                repeat (bit_clks) @(posedge clk_i);
                bits[i] = tx_line_i;
            end
            repeat (bit_clks) @(posedge clk_i);
            ok = tx_line_i;
        end
    endtask
endmodule

// *** bench/asp_serial_port_sva.sv ***
/* Port-level assertions for the serial port.
   Assumes binding to asp_serial_port; sees only its ports. */
`timescale 1ns/1ps
// ============================================================
// Checker
module asp_serial_port_sva (
    input wire        clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [4:2]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        rc_clk_i,
    input wire        xtal_clk_i,
    input wire        rx_i,
    input wire        tx_o,
    input wire [1:0]  irq_high_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A request still waiting, and two quiet cycles on the bus
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_quiet;
        !wb_ack_o ##1 !wb_ack_o;
    endsequence
    // Reset must win even while it is held, so it has its own disable
    property p_rst;
        @(posedge clk_i) disable iff (1'b0)
        rst_i |=> !wb_ack_o && tx_o && (irq_high_o == 2'b00) && (wb_dat_o == 32'h0);
    endproperty
    chk_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack missing");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
    chk_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
    chk_unmapped_zero: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i[4:3] == 2'b11)
        |-> wb_dat_o == 32'h0) else $error("unmapped read nonzero");
    chk_dat_hold: assert property (s_quiet |-> $stable(wb_dat_o)) else $error("read data moved");
    chk_txe_pulse: assert property (irq_high_o[1] |=> !irq_high_o[1]) else $error("tx irq long");
    chk_rxf_pulse: assert property (irq_high_o[0] |=> !irq_high_o[0]) else $error("rx irq long");
    chk_reset_idle: assert property (p_rst) else $error("reset state wrong");
endmodule
bind asp_serial_port asp_serial_port_sva u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rc_clk_i(rc_clk_i), .xtal_clk_i(xtal_clk_i), .rx_i(rx_i),
    .tx_o(tx_o), .irq_high_o(irq_high_o));

// *** bench/tb_async_serial_port_with_baud_select.sv ***
/* Self-checking bench: registers over Wishbone, frames against the remote model.
   Assumes the checker binds itself to the port. */
`timescale 1ns/1ps
`include "asp_regs.vh"
`define CHECK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
    $display("mismatch %s expected %h seen %h", what, exp, got); end end
// ============================================================
// Bench
module tb_async_serial_port_with_baud_select;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [4:2]  wb_adr_i = 3'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic        wb_ack_o, tx_o, rc_clk_i = 1'b0, xtal_clk_i = 1'b0, ok;
    wire         rx_i;
    logic [1:0]  irq_high_o;
    logic [7:0]  rd, d;
    logic [8:0]  bits, ex;
    int          num_errors = 0, tests_run = 0, n_txe = 0, n_rxf = 0, k, m, osc = 0;
    int          rates[4] = '{38400, 57600, 28800, 14400};
    initial forever #25 clk_i = ~clk_i;
    // RC ticks every 4 clocks, crystal every 6, so the two sources differ
    always @(posedge clk_i) begin
        osc <= osc + 1;
        if (osc % 2 == 1) rc_clk_i <= ~rc_clk_i;
        if (osc % 3 == 2) xtal_clk_i <= ~xtal_clk_i;
        if (irq_high_o[1] === 1'b1) n_txe <= n_txe + 1;
        if (irq_high_o[0] === 1'b1) n_rxf <= n_rxf + 1;
    end
    asp_serial_port dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rc_clk_i(rc_clk_i), .xtal_clk_i(xtal_clk_i),
        .rx_i(rx_i), .tx_o(tx_o), .irq_high_o(irq_high_o));
    asp_remote_end far (.clk_i(clk_i), .tx_line_i(tx_o), .rx_line_o(rx_i));
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Classic cycle: hold until ack is sampled at a rising edge, release at that same edge
    task automatic wb(input logic we, input logic [2:0] idx, input logic [7:0] wd);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= idx;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, wd};
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        if (wb_ack_o !== 1'b1) begin
            num_errors++;
            complete_run();
        end
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic reg_is(input string what, input logic [2:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        `CHECK(what, exp, rd)
    endtask
    function automatic logic par_bit(input logic [7:0] v, input logic even);
        return even ? ^v : ~^v;
    endfunction
    // Send one byte from the port and compare the frame seen on the pad
    task automatic tx_frame(input logic [7:0] v, input int n, input logic pe, input logic ev);
        ex = (n == 8) ? {1'b0, v} : {2'b00, v[6:0]};
        if (pe) ex[n] = par_bit(ex[7:0], ev);
        fork
            wb(1'b1, `ASP_IDX_TX_DATA, v);
            far.catch(n + pe, bits, ok);
        join
        `CHECK("tx frame", ex, bits)
        `CHECK("tx stop", 1'b1, ok)
        repeat (far.bit_clks) @(posedge clk_i);
    endtask
    initial begin
        k = $urandom(32'hc85cf463);
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        reg_is("command", `ASP_IDX_COMMAND, 8'h01);
        reg_is("control", `ASP_IDX_CONTROL, 8'h05);
        for (m = 2; m < 7; m++) reg_is("reset word", m[2:0], 8'h00);
        $display("test reset done");
        for (m = 0; m < 4; m++) begin
            // Receive enables kept clear so an inverted idle pad cannot start a stray frame
            d = $urandom & 8'hbf;
            wb(1'b1, m[0] ? `ASP_IDX_CONTROL : `ASP_IDX_COMMAND, d);
            reg_is("config rw", m[0] ? `ASP_IDX_CONTROL : `ASP_IDX_COMMAND, d);
        end
        wb(1'b1, `ASP_IDX_TX_STATUS, 8'hff);
        reg_is("tx status ro", `ASP_IDX_TX_STATUS, 8'h00);
        $display("test config done");
        wb(1'b1, `ASP_IDX_COMMAND, 8'h01);
        wb(1'b1, `ASP_IDX_CONTROL, 8'h07);
        d = $urandom;
        wb(1'b1, `ASP_IDX_TX_DATA, d);
        reg_is("tx full", `ASP_IDX_TX_STATUS, 8'h01);
        k = n_txe;
        fork
            wb(1'b1, `ASP_IDX_CONTROL, 8'h27);
            far.catch(8, bits, ok);
        join
        `CHECK("held byte", {1'b0, d}, bits)
        reg_is("tx emptied", `ASP_IDX_TX_STATUS, 8'h02);
        `CHECK("tx irq", k + 1, n_txe)
        $display("test tx flag done");
        for (m = 0; m < 8; m++) begin
            wb(1'b1, `ASP_IDX_COMMAND, {5'h0, m[2:0]});
            tx_frame($urandom, m[0] ? 8 : 7, m[1], m[2]);
        end
        wb(1'b1, `ASP_IDX_COMMAND, 8'h01);
        for (m = 0; m < 4; m++) begin
            wb(1'b1, `ASP_IDX_CONTROL, 8'h27 - m[7:0]);
            far.bit_clks = (64 * 38400 + rates[m] / 2) / rates[m];
            tx_frame($urandom, 8, 1'b0, 1'b0);
        end
        $display("test tx modes done");
        far.bit_clks = 64;
        wb(1'b1, `ASP_IDX_CONTROL, 8'h2f);
        repeat (6) @(posedge clk_i);
        `CHECK("inverted idle", 1'b0, tx_o)
        wb(1'b1, `ASP_IDX_CONTROL, 8'h87);
        // Echo path lags by the pad synchroniser and the output flop
        repeat (2) @(posedge clk_i);
        d = $urandom;
        fork
            far.send({1'b0, d}, 8);
            far.catch(8, bits, ok);
        join
        `CHECK("echo", {1'b0, d}, bits)
        $display("test pads done");
        wb(1'b1, `ASP_IDX_CONTROL, 8'h07);
        far.send({1'b0, d}, 8);
        reg_is("rx off", `ASP_IDX_RX_STATUS, 8'h00);
        wb(1'b1, `ASP_IDX_CONTROL, 8'h47);
        k = n_rxf;
        far.send({1'b0, d}, 8);
        reg_is("rx full", `ASP_IDX_RX_STATUS, 8'h01);
        reg_is("rx data", `ASP_IDX_RX_DATA, d);
        reg_is("rx read clears", `ASP_IDX_RX_STATUS, 8'h00);
        `CHECK("rx irq", k + 1, n_rxf)
        wb(1'b1, `ASP_IDX_CONTROL, 8'h07);
        wb(1'b1, `ASP_IDX_COMMAND, 8'h41);
        far.send({1'b0, d}, 8);
        d = $urandom;
        far.send({1'b0, d}, 8);
        reg_is("overrun", `ASP_IDX_RX_STATUS, 8'h05);
        reg_is("newest word", `ASP_IDX_RX_DATA, d);
        wb(1'b1, `ASP_IDX_RX_STATUS, $urandom);
        reg_is("overrun cleared", `ASP_IDX_RX_STATUS, 8'h00);
        wb(1'b1, `ASP_IDX_COMMAND, 8'h43);
        far.send({~par_bit(d, 1'b0), d}, 9);
        reg_is("parity error", `ASP_IDX_RX_STATUS, 8'h11);
        reg_is("rx data", `ASP_IDX_RX_DATA, d);
        $display("test rx done");
        // Crystal: 7 ticks a bit, the source of the fixed rate error
        wb(1'b1, `ASP_IDX_COMMAND, 8'h89);
        wb(1'b1, `ASP_IDX_CONTROL, 8'h23);
        far.bit_clks = 84;
        tx_frame($urandom, 8, 1'b0, 1'b0);
        $display("test crystal done");
        complete_run();
    end
endmodule

// *** inc/asp_regs.vh ***
/*
 * Register map, field positions, reset values and bit-timing constants of
 * the asynchronous serial port.
 * Assumes inclusion by bare name from design files that need these values.
 */
`ifndef ASP_REGS_VH
`define ASP_REGS_VH

// ============================================================================
// Register word indices (byte address = index * 4)
`define ASP_IDX_COMMAND      3'h0
`define ASP_IDX_CONTROL      3'h1
`define ASP_IDX_TX_DATA      3'h2
`define ASP_IDX_TX_STATUS    3'h3
`define ASP_IDX_RX_DATA      3'h4
`define ASP_IDX_RX_STATUS    3'h5

// ============================================================================
// Command register fields
`define ASP_CMD_CLK_SRC      7
`define ASP_CMD_RX_EN_B      6
`define ASP_CMD_PRESC_HI     5
`define ASP_CMD_PRESC_LO     3
`define ASP_CMD_PAR_SENSE    2
`define ASP_CMD_PAR_EN       1
`define ASP_CMD_WORD_LEN     0
`define ASP_CMD_RESET        8'h01

// ============================================================================
// Control register fields
`define ASP_CTL_ECHO         7
`define ASP_CTL_RX_EN_A      6
`define ASP_CTL_TX_EN        5
`define ASP_CTL_RX_INV       4
`define ASP_CTL_TX_INV       3
`define ASP_CTL_BAUD_HI      2
`define ASP_CTL_BAUD_LO      0
`define ASP_CTL_RESET        8'h05

// ============================================================================
// Status register fields
`define ASP_TXS_FULL         0
`define ASP_TXS_BUSY         1
`define ASP_RXS_FULL         0
`define ASP_RXS_BUSY         1
`define ASP_RXS_OVERRUN      2
`define ASP_RXS_FRAME        3
`define ASP_RXS_PARITY       4
`define ASP_RXS_START        5
`define ASP_DATA_RESET       8'h00

// ============================================================================
// Bit timing: periods counted in thirds of a prescaled oscillator edge
`define ASP_PHASE_STEP       10'h003
`define ASP_PER_RC_111       9'h030
`define ASP_PER_RC_110       9'h020
`define ASP_PER_RC_101       9'h040
`define ASP_PER_RC_100       9'h080
`define ASP_PER_XTAL_BASE    9'h015

`endif

// *** src/asp_bit_timer.v ***
/*
 * Fractional bit timer: accumulates a fixed phase step per prescaled clock
 * tick and strobes once per bit period, keeping the remainder.
 * Assumes tick_i is a one-cycle pulse on clk_i.
 */
`timescale 1ns/1ps
`include "asp_regs.vh"

module asp_bit_timer (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       tick_i,
    input  wire       run_i,
    input  wire       load_i,
    input  wire [8:0] preload_i,
    input  wire [8:0] period_i,
    output wire       strobe_o
);

    reg  [9:0] acc_r;
    reg        strobe_r;
    wire [9:0] sum;

    assign sum      = acc_r + `ASP_PHASE_STEP;
    assign strobe_o = strobe_r;

    // ========================================================================
    // Phase accumulator; remainder carried so non-integer ratios stay exact
    always @(posedge clk_i) begin
        if (rst_i) begin
            acc_r    <= 10'h000;
            strobe_r <= 1'b0;
        end else begin
            strobe_r <= 1'b0;
            if (load_i) begin
                acc_r <= {1'b0, preload_i};
            end else if (run_i && tick_i) begin
                if (sum >= {1'b0, period_i}) begin
                    acc_r    <= sum - {1'b0, period_i};
                    strobe_r <= 1'b1;
                end else begin
                    acc_r <= sum;
                end
            end
        end
    end

endmodule

// *** src/asp_serial_port.v ***
/*
 * Full-duplex asynchronous serial port with baud select, reached over a
 * classic Wishbone slave with 32-bit data.
 * Assumes rc_clk_i and xtal_clk_i are oscillator clocks well below clk_i/2
 * and rx_i is an asynchronous pad; all three are synchronised here.
 */
`timescale 1ns/1ps
`include "asp_regs.vh"

module asp_serial_port (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [4:2]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    input  wire        rc_clk_i,
    input  wire        xtal_clk_i,
    input  wire        rx_i,
    output wire        tx_o,
    output wire [1:0]  irq_high_o
);

    localparam ST_IDLE  = 3'h0;
    localparam ST_START = 3'h1;
    localparam ST_DATA  = 3'h2;
    localparam ST_PAR   = 3'h3;
    localparam ST_STOP  = 3'h4;

    reg  [7:0]  cmd_r;
    reg  [7:0]  ctl_r;
    reg  [7:0]  tx_data_r;
    reg         tx_full_r;
    reg  [7:0]  rx_data_r;
    reg         rx_full_r;
    reg         ovr_r;
    reg         frm_err_r;
    reg         par_err_r;
    reg         st_err_r;
    reg         ack_r;
    reg  [31:0] dat_r;
    reg  [1:0]  irq_r;
    reg  [2:0]  rc_sync_r;
    reg  [2:0]  xt_sync_r;
    reg  [1:0]  rx_sync_r;
    reg  [7:0]  presc_cnt_r;
    reg         tick_r;
    reg  [2:0]  tx_st_r;
    reg  [7:0]  tx_sh_r;
    reg  [2:0]  tx_cnt_r;
    reg         tx_par_r;
    reg         tx_bit_r;
    reg         tx_out_r;
    reg  [2:0]  rx_st_r;
    reg  [7:0]  rx_sh_r;
    reg  [2:0]  rx_cnt_r;
    reg         rx_st_bad_r;
    reg         rx_par_r;
    reg  [8:0]  period;
    reg  [7:0]  rd_mux;

    wire        acc_en;
    wire        wr_en;
    wire        rd_en;
    wire        src_edge;
    wire [7:0]  presc_mask;
    wire        rx_line;
    wire        rx_enable;
    wire [2:0]  last_bit;
    wire        tx_load;
    wire        tx_strobe;
    wire        rx_strobe;
    wire        rx_begin;
    wire        rx_done;
    wire [7:0]  tx_word;
    wire [7:0]  rx_word;
    wire        rx_par_calc;

    // ========================================================================
    // Wishbone access: one access per request, ack one cycle after strobe
    assign acc_en   = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr_en    = acc_en & wb_we_i & wb_sel_i[0];
    assign rd_en    = acc_en & ~wb_we_i;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // Read mux; unmapped words read as zero
    always @* begin
        case (wb_adr_i)
            `ASP_IDX_COMMAND:   rd_mux = cmd_r;
            `ASP_IDX_CONTROL:   rd_mux = ctl_r;
            `ASP_IDX_TX_DATA:   rd_mux = tx_data_r;
            `ASP_IDX_TX_STATUS: rd_mux = {6'h00, tx_st_r != ST_IDLE, tx_full_r};
            `ASP_IDX_RX_DATA:   rd_mux = rx_data_r;
            `ASP_IDX_RX_STATUS: rd_mux = {2'h0, st_err_r, par_err_r, frm_err_r, ovr_r,
                                          rx_st_r != ST_IDLE, rx_full_r};
            default:            rd_mux = 8'h00;
        endcase
    end

    // Bus handshake and configuration registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_r     <= 1'b0;
            dat_r     <= 32'h0000_0000;
            cmd_r     <= `ASP_CMD_RESET;
            ctl_r     <= `ASP_CTL_RESET;
            tx_data_r <= `ASP_DATA_RESET;
        end else begin
            ack_r <= acc_en;
            if (rd_en) begin
                dat_r <= {24'h00_0000, rd_mux};
            end
            if (wr_en && wb_adr_i == `ASP_IDX_COMMAND) begin
                cmd_r <= wb_dat_i[7:0];
            end
            if (wr_en && wb_adr_i == `ASP_IDX_CONTROL) begin
                ctl_r <= wb_dat_i[7:0];
            end
            if (wr_en && wb_adr_i == `ASP_IDX_TX_DATA) begin
                tx_data_r <= wb_dat_i[7:0];
            end
        end
    end

    // ========================================================================
    // Oscillator and pad synchronisers; third stage only for edge detection
    always @(posedge clk_i) begin
        if (rst_i) begin
            rc_sync_r <= 3'h0;
            xt_sync_r <= 3'h0;
            rx_sync_r <= 2'h3;
        end else begin
            rc_sync_r <= {rc_sync_r[1:0], rc_clk_i};
            xt_sync_r <= {xt_sync_r[1:0], xtal_clk_i};
            rx_sync_r <= {rx_sync_r[0], rx_i};
        end
    end

    // Source select then 2^code prescaler, one tick per divided edge
    assign src_edge   = cmd_r[`ASP_CMD_CLK_SRC] ? (xt_sync_r[1] & ~xt_sync_r[2])
                                                : (rc_sync_r[1] & ~rc_sync_r[2]);
    assign presc_mask = ~(8'hff << cmd_r[`ASP_CMD_PRESC_HI:`ASP_CMD_PRESC_LO]);

    always @(posedge clk_i) begin
        if (rst_i) begin
            presc_cnt_r <= 8'h00;
            tick_r      <= 1'b0;
        end else begin
            tick_r <= src_edge && ((presc_cnt_r & presc_mask) == presc_mask);
            if (src_edge) begin
                presc_cnt_r <= presc_cnt_r + 8'h01;
            end
        end
    end

    // Bit period in thirds of a tick; RC base is 614400 Hz after prescale.
    // Crystal needs 7 ticks per 2400 baud bit, hence the fixed rate error.
    always @* begin
        if (cmd_r[`ASP_CMD_CLK_SRC]) begin
            period = `ASP_PER_XTAL_BASE << (2'h3 - ctl_r[1:0]);
        end else begin
            case (ctl_r[`ASP_CTL_BAUD_HI:`ASP_CTL_BAUD_LO])
                3'h7:    period = `ASP_PER_RC_111;
                3'h6:    period = `ASP_PER_RC_110;
                3'h5:    period = `ASP_PER_RC_101;
                default: period = `ASP_PER_RC_100;
            endcase
        end
    end

    // ========================================================================
    // Transmitter
    assign last_bit  = cmd_r[`ASP_CMD_WORD_LEN] ? 3'h7 : 3'h6;
    assign tx_word   = cmd_r[`ASP_CMD_WORD_LEN] ? tx_data_r : {1'b0, tx_data_r[6:0]};
    assign tx_load   = (tx_st_r == ST_IDLE) & tx_full_r & ctl_r[`ASP_CTL_TX_EN];

    asp_bit_timer u_tx_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .tick_i    (tick_r),
        .run_i     (tx_st_r != ST_IDLE),
        .load_i    (tx_load),
        .preload_i (9'h000),
        .period_i  (period),
        .strobe_o  (tx_strobe)
    );

    // Holding flag: a write in the load cycle keeps it set
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_full_r <= 1'b0;
        end else begin
            tx_full_r <= (wr_en && wb_adr_i == `ASP_IDX_TX_DATA) | (tx_full_r & ~tx_load);
        end
    end

    // Frame sequencer; disabling transmit lets a running frame finish
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_st_r  <= ST_IDLE;
            tx_sh_r  <= 8'h00;
            tx_cnt_r <= 3'h0;
            tx_par_r <= 1'b0;
            tx_bit_r <= 1'b1;
        end else begin
            case (tx_st_r)
                ST_IDLE: begin
                    tx_bit_r <= 1'b1;
                    if (tx_load) begin
                        tx_sh_r  <= tx_word;
                        tx_par_r <= cmd_r[`ASP_CMD_PAR_SENSE] ? ^tx_word : ~^tx_word;
                        tx_bit_r <= 1'b0;
                        tx_st_r  <= ST_START;
                    end
                end
                ST_START: begin
                    if (tx_strobe) begin
                        tx_bit_r <= tx_sh_r[0];
                        tx_cnt_r <= 3'h0;
                        tx_st_r  <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (tx_strobe) begin
                        if (tx_cnt_r == last_bit) begin
                            if (cmd_r[`ASP_CMD_PAR_EN]) begin
                                tx_bit_r <= tx_par_r;
                                tx_st_r  <= ST_PAR;
                            end else begin
                                tx_bit_r <= 1'b1;
                                tx_st_r  <= ST_STOP;
                            end
                        end else begin
                            tx_bit_r <= tx_sh_r[1];
                            tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
                            tx_cnt_r <= tx_cnt_r + 3'h1;
                        end
                    end
                end
                ST_PAR: begin
                    if (tx_strobe) begin
                        tx_bit_r <= 1'b1;
                        tx_st_r  <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (tx_strobe) begin
                        tx_st_r <= ST_IDLE;
                    end
                end
                default: tx_st_r <= ST_IDLE;
            endcase
        end
    end

    // Pad driver: echo bypasses the shifter and uses the synchronised pad level, without receive inversion
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_out_r <= 1'b1;
        end else if (ctl_r[`ASP_CTL_ECHO]) begin
            tx_out_r <= rx_sync_r[1] ^ ctl_r[`ASP_CTL_TX_INV];
        end else begin
            tx_out_r <= tx_bit_r ^ ctl_r[`ASP_CTL_TX_INV];
        end
    end
    assign tx_o = tx_out_r;

    // ========================================================================
    // Receiver
    assign rx_line   = rx_sync_r[1] ^ ctl_r[`ASP_CTL_RX_INV];
    assign rx_enable = cmd_r[`ASP_CMD_RX_EN_B] | ctl_r[`ASP_CTL_RX_EN_A];
    assign rx_begin  = (rx_st_r == ST_IDLE) & rx_enable & ~rx_line;
    assign rx_done   = (rx_st_r == ST_STOP) & rx_strobe;
    assign rx_word   = cmd_r[`ASP_CMD_WORD_LEN] ? rx_sh_r : {1'b0, rx_sh_r[6:0]};
    assign rx_par_calc = cmd_r[`ASP_CMD_PAR_SENSE] ? ^rx_word : ~^rx_word;

    // Half-period preload puts every sample at mid-bit
    asp_bit_timer u_rx_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .tick_i    (tick_r),
        .run_i     (rx_st_r != ST_IDLE),
        .load_i    (rx_begin),
        .preload_i ({1'b0, period[8:1]}),
        .period_i  (period),
        .strobe_o  (rx_strobe)
    );

    // Frame sequencer; stop sample ends the frame and hands the word over
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_st_r     <= ST_IDLE;
            rx_sh_r     <= 8'h00;
            rx_cnt_r    <= 3'h0;
            rx_st_bad_r <= 1'b0;
            rx_par_r    <= 1'b0;
        end else begin
            case (rx_st_r)
                ST_IDLE: begin
                    if (rx_begin) begin
                        rx_sh_r <= 8'h00;
                        rx_st_r <= ST_START;
                    end
                end
                ST_START: begin
                    if (rx_strobe) begin
                        rx_st_bad_r <= rx_line;
                        rx_cnt_r    <= 3'h0;
                        rx_st_r     <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (rx_strobe) begin
                        rx_sh_r[rx_cnt_r] <= rx_line;
                        rx_cnt_r          <= rx_cnt_r + 3'h1;
                        if (rx_cnt_r == last_bit) begin
                            rx_st_r <= cmd_r[`ASP_CMD_PAR_EN] ? ST_PAR : ST_STOP;
                        end
                    end
                end
                ST_PAR: begin
                    if (rx_strobe) begin
                        rx_par_r <= rx_line;
                        rx_st_r  <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (rx_strobe) begin
                        rx_st_r <= ST_IDLE;
                    end
                end
                default: rx_st_r <= ST_IDLE;
            endcase
        end
    end

    // Receive holding and status; setting events win over software clears
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_data_r <= `ASP_DATA_RESET;
            rx_full_r <= 1'b0;
            ovr_r     <= 1'b0;
            frm_err_r <= 1'b0;
            par_err_r <= 1'b0;
            st_err_r  <= 1'b0;
        end else begin
            rx_full_r <= rx_done | (rx_full_r & ~(rd_en && wb_adr_i == `ASP_IDX_RX_DATA));
            ovr_r     <= (rx_done & rx_full_r) |
                         (ovr_r & ~(wr_en && wb_adr_i == `ASP_IDX_RX_STATUS));
            if (rx_done) begin
                rx_data_r <= rx_word;
                frm_err_r <= ~rx_line;
                par_err_r <= cmd_r[`ASP_CMD_PAR_EN] & (rx_par_r != rx_par_calc);
                st_err_r  <= rx_st_bad_r;
            end
        end
    end

    // ========================================================================
    // Interrupt lines: pulse on holding drain and on new received word
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_r <= 2'h0;
        end else begin
            irq_r <= {tx_load, rx_done};
        end
    end
    assign irq_high_o = irq_r;

endmodule
